// File: bsd_pkg.sv
package bsd_pkg;

  // Register offsets on the serial control bus
  localparam logic [7:0] ADDR_STATUS = 8'h50;
  localparam logic [7:0] ADDR_DESC_ID = 8'h51;
  localparam logic [7:0] ADDR_TIMING = 8'h52;
  localparam logic [7:0] ADDR_DELAY = 8'h53;
  localparam logic [7:0] ADDR_BRIDGE = 8'h54;

  // Descriptor address register
  localparam logic [6:0] SLAVE_ADDR_RESET = 7'h50;
  localparam logic WRITE_PROTECT_RESET = 1'b0;
  localparam int SLAVE_MSB = 7;
  localparam int SLAVE_LSB = 1;
  localparam int WP_BIT = 0;

  // Timing register fields
  localparam logic [2:0] HOLD_RESET = 3'h1;
  localparam logic [3:0] FILTER_RESET = 4'hE;
  localparam int HOLD_MSB = 6;
  localparam int HOLD_LSB = 4;
  localparam int FILTER_MSB = 3;
  localparam int FILTER_LSB = 0;

  // Output delay register field
  localparam logic [1:0] DELAY_RESET = 2'h0;
  localparam int DELAY_MSB = 1;
  localparam int DELAY_LSB = 0;

  // Status bit positions
  localparam int ST_RX_IRQ = 6;
  localparam int ST_REM_LOADED = 3;

  // Timing in ns and the clock period
  localparam int CLK_PERIOD_NS = 10;
  localparam int HOLD_STEP_NS = 40;
  localparam int FILTER_STEP_NS = 5;
  localparam int DELAY_BASE_NS = 240;
  localparam int DELAY_STEP_NS = 40;

  // Descriptor memory shape
  localparam int MEM_AW = 8;
  localparam int MEM_DW = 8;

  typedef struct packed {
    logic external_control_sel;
    logic irq_en;
    logic remote_descriptor_load_off;
    logic receiver_autosetup_off;
    logic protect_autosetup_off;
    logic audio_tdm;
    logic spare;
    logic aux_audio_en;
  } bsd_bridge_cfg_t;

  localparam bsd_bridge_cfg_t BRIDGE_RESET = 8'h00;

  typedef struct packed {
    logic [2:0] data_hold_qualify;
    logic [3:0] glitch_filter_depth;
  } bsd_timing_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_WDATA = 3'b011,
    ST_WACK = 3'b100,
    ST_RDATA = 3'b101,
    ST_RACK = 3'b110
  } bsd_ddc_state_t;

endpackage

// File: bsd_desc_mem.sv
`timescale 1ns/1ps
module bsd_desc_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // Clock
  input wire logic clk_i,
  // Access
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end

endmodule

// File: bsd_top.sv
`timescale 1ns/1ps
// How it works
// - Descriptor memory answers at programmed 7-bit address
// - Write protect bit blocks display channel writes to descriptor memory
// - Hold time qualifies start and stop detection
// - Glitch filter drops short pulses on inputs
// - Data output delayed after clock fall by code
// - External control strap disables receiver init, protection setup and remote load
// - Interrupt enable routes receiver interrupt to pin
// - Remote descriptor load after reset unless external control strap set
// - Receiver auto init unless disable bit set
// - Protection register setup unless disable bit set
// - TDM audio bit enables multiplexed audio
// - Auxiliary audio bit enables extra stereo stream
// - Auxiliary audio bit loaded from second strap
// - Status bit 6 shows pending receiver interrupt
// - Status bit 3 set after remote load
module bsd_top (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Display channel pins
  input wire logic ddc_scl_i,
  input wire logic ddc_sda_i,
  output logic ddc_sda_o,
  output logic ddc_sda_oe_o,
  // Strap pins
  input wire logic strap_pin_a_i,
  input wire logic strap_pin_b_i,
  // Receiver interrupt and pin
  input wire logic rx_irq_i,
  output logic irq_out_n_o,
  // Remote descriptor load
  input wire logic remote_wr_i,
  input wire logic [bsd_pkg::MEM_AW-1:0] remote_addr_i,
  input wire logic [bsd_pkg::MEM_DW-1:0] remote_data_i,
  input wire logic remote_done_i,
  output logic remote_load_start_o,
  // Bridge control
  output logic receiver_init_en_o,
  output logic protect_setup_en_o,
  output logic audio_tdm_en_o,
  output logic aux_audio_en_o
);
  import bsd_pkg::*;

  function automatic logic [7:0] filter_lim(input logic [3:0] d);
    filter_lim = 8'((int'(d) * FILTER_STEP_NS + CLK_PERIOD_NS - 1)
                    / CLK_PERIOD_NS);
  endfunction

  // Registers
  logic [6:0] descriptor_slave_addr;
  logic descriptor_write_protect;
  bsd_timing_cfg_t tcfg;
  logic [1:0] data_output_delay;
  bsd_bridge_cfg_t bcfg;
  logic remote_descriptor_loaded;
  logic strap_done;
  logic [1:0] strap_cnt;
  logic [1:0] strap_a_s;
  logic [1:0] strap_b_s;
  logic [6:0] next_slave_addr;
  logic next_wp;
  bsd_timing_cfg_t next_tcfg;
  logic [1:0] next_delay;
  bsd_bridge_cfg_t next_bcfg;
  logic next_loaded;
  logic [7:0] next_rdata;

  // Input filter
  logic [1:0] raw_s1;
  logic [1:0] raw_s2;
  logic [1:0] filt;
  logic [1:0] filt_q;
  logic [7:0] fcnt [0:1];
  logic [1:0] next_filt;
  logic [7:0] next_fcnt [0:1];

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      raw_s1 <= 2'h3;
      raw_s2 <= 2'h3;
      filt_q <= 2'h3;
    end
    else
    begin
      raw_s1 <= {ddc_sda_i, ddc_scl_i};
      raw_s2 <= raw_s1;
      filt_q <= filt;
    end
  end

  for (genvar g = 0; g < 2; g++)
  begin : g_filt
    always_comb
    begin
      next_filt[g] = filt[g];
      next_fcnt[g] = 8'h00;
      if (raw_s2[g] != filt[g])
      begin
        if (fcnt[g] >= filter_lim(tcfg.glitch_filter_depth))
        begin
          next_filt[g] = raw_s2[g];
        end
        else
        begin
          next_fcnt[g] = fcnt[g] + 8'h01;
        end
      end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
      begin
        filt[g] <= 1'b1;
        fcnt[g] <= 8'h00;
      end
      else
      begin
        filt[g] <= next_filt[g];
        fcnt[g] <= next_fcnt[g];
      end
    end
  end

  logic scl_f;
  logic sda_f;
  logic scl_rise;
  logic scl_fall;
  assign scl_f = filt[0];
  assign sda_f = filt[1];
  assign scl_rise = filt[0] & ~filt_q[0];
  assign scl_fall = ~filt[0] & filt_q[0];

  // Start and stop qualification
  logic q_arm;
  logic q_kind;
  logic [7:0] q_cnt;
  logic start_p;
  logic stop_p;
  logic next_q_arm;
  logic next_q_kind;
  logic [7:0] next_q_cnt;
  logic next_start_p;
  logic next_stop_p;

  always_comb
  begin
    next_q_arm = q_arm;
    next_q_kind = q_kind;
    next_q_cnt = q_cnt;
    next_start_p = 1'b0;
    next_stop_p = 1'b0;
    if (scl_f && filt_q[0] && sda_f != filt_q[1])
    begin
      next_q_arm = 1'b1;
      next_q_kind = sda_f;
      next_q_cnt = 8'(int'(tcfg.data_hold_qualify) * HOLD_STEP_NS
                      / CLK_PERIOD_NS);
    end
    else if (q_arm)
    begin
      if (!scl_f || sda_f != q_kind)
      begin
        next_q_arm = 1'b0;
      end
      else if (q_cnt == 8'h00)
      begin
        next_q_arm = 1'b0;
        next_start_p = ~q_kind;
        next_stop_p = q_kind;
      end
      else
      begin
        next_q_cnt = q_cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      q_arm <= 1'b0;
      q_kind <= 1'b0;
      q_cnt <= 8'h00;
      start_p <= 1'b0;
      stop_p <= 1'b0;
    end
    else
    begin
      q_arm <= next_q_arm;
      q_kind <= next_q_kind;
      q_cnt <= next_q_cnt;
      start_p <= next_start_p;
      stop_p <= next_stop_p;
    end
  end

  // Display channel slave
  bsd_ddc_state_t state;
  logic [3:0] bitcnt;
  logic [7:0] sh;
  logic [7:0] ptr;
  logic rw;
  logic first_byte;
  logic wrote;
  logic mst_nack;
  logic drv_want;
  logic [7:0] dly_cnt;
  logic dly_pend;
  logic mem_we;
  logic [7:0] mem_rdata;
  bsd_ddc_state_t next_state;
  logic [3:0] next_bitcnt;
  logic [7:0] next_sh;
  logic [7:0] next_ptr;
  logic next_rw;
  logic next_first;
  logic next_wrote;
  logic next_nack;
  logic next_drv;
  logic [7:0] next_dly;
  logic next_pend;
  logic next_oe;
  logic next_we;

  always_comb
  begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_sh = sh;
    next_ptr = ptr;
    next_rw = rw;
    next_first = first_byte;
    next_wrote = wrote;
    next_nack = mst_nack;
    next_drv = drv_want;
    next_dly = dly_cnt;
    next_pend = dly_pend;
    next_oe = ddc_sda_oe_o;
    next_we = 1'b0;
    if (start_p || stop_p)
    begin
      next_state = start_p ? ST_ADDR : ST_IDLE;
      next_bitcnt = 4'h0;
      next_drv = 1'b0;
      next_pend = 1'b0;
      next_oe = 1'b0;
    end
    else if (scl_rise)
    begin
      case (state)
        ST_ADDR, ST_WDATA:
        begin
          next_sh = {sh[6:0], sda_f};
          next_bitcnt = bitcnt + 4'h1;
        end
        ST_RDATA: next_bitcnt = bitcnt + 4'h1;
        ST_RACK: next_nack = sda_f;
        default: next_bitcnt = bitcnt;
      endcase
    end
    else if (scl_fall)
    begin
      next_pend = 1'b1;
      next_dly = 8'((DELAY_BASE_NS + int'(data_output_delay) * DELAY_STEP_NS
                     + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
      next_drv = 1'b0;
      case (state)
        ST_ADDR:
        begin
          if (bitcnt == 4'h8)
          begin
            if (sh[7:1] == descriptor_slave_addr)
            begin
              next_state = ST_ADDR_ACK;
              next_drv = 1'b1;
              next_rw = sh[0];
            end
            else
            begin
              next_state = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK, ST_RACK:
        begin
          if (state == ST_RACK && mst_nack)
          begin
            next_state = ST_IDLE;
          end
          else if (state == ST_RACK || rw)
          begin
            next_state = ST_RDATA;
            next_sh = mem_rdata;
            next_drv = ~mem_rdata[7];
            next_bitcnt = 4'h0;
          end
          else
          begin
            next_state = ST_WDATA;
            next_bitcnt = 4'h0;
            next_first = 1'b1;
          end
        end
        ST_WDATA:
        begin
          if (bitcnt == 4'h8)
          begin
            next_state = ST_WACK;
            next_wrote = 1'b0;
            if (first_byte)
            begin
              next_ptr = sh;
              next_drv = 1'b1;
            end
            else if (!descriptor_write_protect)
            begin
              next_we = 1'b1;
              next_wrote = 1'b1;
              next_drv = 1'b1;
            end
          end
        end
        ST_WACK:
        begin
          next_state = ST_WDATA;
          next_bitcnt = 4'h0;
          next_first = 1'b0;
          if (wrote)
          begin
            next_ptr = ptr + 8'h01;
          end
        end
        ST_RDATA:
        begin
          if (bitcnt == 4'h8)
          begin
            next_state = ST_RACK;
            next_ptr = ptr + 8'h01;
          end
          else
          begin
            next_drv = ~sh[6];
            next_sh = {sh[6:0], 1'b0};
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
    else if (dly_pend)
    begin
      if (dly_cnt <= 8'h01)
      begin
        next_pend = 1'b0;
        next_oe = drv_want;
      end
      else
      begin
        next_dly = dly_cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      sh <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      first_byte <= 1'b0;
      wrote <= 1'b0;
      mst_nack <= 1'b0;
      drv_want <= 1'b0;
      dly_cnt <= 8'h00;
      dly_pend <= 1'b0;
      ddc_sda_oe_o <= 1'b0;
      ddc_sda_o <= 1'b0;
      mem_we <= 1'b0;
    end
    else
    begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      sh <= next_sh;
      ptr <= next_ptr;
      rw <= next_rw;
      first_byte <= next_first;
      wrote <= next_wrote;
      mst_nack <= next_nack;
      drv_want <= next_drv;
      dly_cnt <= next_dly;
      dly_pend <= next_pend;
      ddc_sda_oe_o <= next_oe;
      ddc_sda_o <= 1'b0;
      mem_we <= next_we;
    end
  end

  // Remote load has the memory port while it writes
  bsd_desc_mem #(
    .AW(MEM_AW),
    .DW(MEM_DW)
  ) u_mem (
    .clk_i(sys_clk_i),
    .we_i(remote_wr_i | mem_we),
    .addr_i(remote_wr_i ? remote_addr_i : ptr),
    .wdata_i(remote_wr_i ? remote_data_i : sh),
    .rdata_o(mem_rdata)
  );

  // Register file and bridge control
  always_comb
  begin
    next_slave_addr = descriptor_slave_addr;
    next_wp = descriptor_write_protect;
    next_tcfg = tcfg;
    next_delay = data_output_delay;
    next_bcfg = bcfg;
    next_loaded = remote_descriptor_loaded;
    next_rdata = reg_rdata_o;
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        ADDR_DESC_ID:
        begin
          next_slave_addr = reg_wdata_i[SLAVE_MSB:SLAVE_LSB];
          next_wp = reg_wdata_i[WP_BIT];
        end
        ADDR_TIMING: next_tcfg = reg_wdata_i[HOLD_MSB:FILTER_LSB];
        ADDR_DELAY: next_delay = reg_wdata_i[DELAY_MSB:DELAY_LSB];
        ADDR_BRIDGE: next_bcfg = reg_wdata_i;
        default: next_bcfg = bcfg;
      endcase
    end
    if (!strap_done)
    begin
      next_bcfg.external_control_sel = strap_a_s[1];
      next_bcfg.remote_descriptor_load_off = strap_a_s[1];
      next_bcfg.aux_audio_en = strap_b_s[1];
      next_loaded = 1'b0;
    end
    if (remote_done_i)
    begin
      next_loaded = 1'b1;
    end
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        ADDR_STATUS:
        begin
          next_rdata = 8'h00;
          next_rdata[ST_RX_IRQ] = rx_irq_i;
          next_rdata[ST_REM_LOADED] = remote_descriptor_loaded;
        end
        ADDR_DESC_ID:
          next_rdata = {descriptor_slave_addr, descriptor_write_protect};
        ADDR_TIMING: next_rdata = {1'b0, tcfg};
        ADDR_DELAY: next_rdata = {6'h00, data_output_delay};
        ADDR_BRIDGE: next_rdata = bcfg;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      descriptor_slave_addr <= SLAVE_ADDR_RESET;
      descriptor_write_protect <= WRITE_PROTECT_RESET;
      tcfg <= {HOLD_RESET, FILTER_RESET};
      data_output_delay <= DELAY_RESET;
      bcfg <= BRIDGE_RESET;
      remote_descriptor_loaded <= 1'b0;
      strap_a_s <= 2'h0;
      strap_b_s <= 2'h0;
      strap_done <= 1'b0;
      strap_cnt <= 2'h0;
      reg_rdata_o <= 8'h00;
      remote_load_start_o <= 1'b0;
      receiver_init_en_o <= 1'b0;
      protect_setup_en_o <= 1'b0;
      audio_tdm_en_o <= 1'b0;
      aux_audio_en_o <= 1'b0;
      irq_out_n_o <= 1'b1;
    end
    else
    begin
      descriptor_slave_addr <= next_slave_addr;
      descriptor_write_protect <= next_wp;
      tcfg <= next_tcfg;
      data_output_delay <= next_delay;
      bcfg <= next_bcfg;
      remote_descriptor_loaded <= next_loaded;
      strap_a_s <= {strap_a_s[0], strap_pin_a_i};
      strap_b_s <= {strap_b_s[0], strap_pin_b_i};
      // Capture only once the pins have crossed both sync stages
      strap_cnt <= strap_cnt + {1'b0, strap_cnt != 2'h2};
      strap_done <= strap_done | (strap_cnt == 2'h2);
      reg_rdata_o <= next_rdata;
      remote_load_start_o <= (strap_cnt == 2'h2) & ~strap_done
                             & ~strap_a_s[1];
      receiver_init_en_o <= strap_done & ~bcfg.external_control_sel
                            & ~bcfg.receiver_autosetup_off;
      protect_setup_en_o <= strap_done & ~bcfg.external_control_sel
                            & ~bcfg.protect_autosetup_off;
      audio_tdm_en_o <= bcfg.audio_tdm;
      aux_audio_en_o <= bcfg.aux_audio_en;
      irq_out_n_o <= ~(bcfg.irq_en & rx_irq_i);
    end
  end

endmodule

// File: bsd_chk.sv
`timescale 1ns/1ps
module bsd_chk
  import bsd_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  // Control pins
  input wire logic rx_irq_i,
  input wire logic irq_out_n_o,
  input wire logic remote_load_start_o,
  input wire logic receiver_init_en_o,
  input wire logic protect_setup_en_o,
  input wire logic audio_tdm_en_o,
  input wire logic aux_audio_en_o,
  // Strap pins
  input wire logic strap_pin_a_i,
  input wire logic strap_pin_b_i
);
  logic [7:0] sh;
  logic [1:0] stab;
  logic [1:0] age;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Bridge register shadow and cycles since it changed
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sh <= 8'h00;
      stab <= 2'h0;
      age <= 2'h0;
    end
    else
    begin
      if (age != 2'h3)
      begin
        age <= age + 2'h1;
      end
      if (reg_wr_i && reg_addr_i == ADDR_BRIDGE)
      begin
        sh <= reg_wdata_i;
        stab <= 2'h0;
      end
      else if (age == 2'h2)
      begin
        // Strap bits land in the third cycle after reset
        sh[7] <= strap_pin_a_i;
        sh[5] <= strap_pin_a_i;
        sh[0] <= strap_pin_b_i;
        stab <= 2'h0;
      end
      else if (stab != 2'h3)
      begin
        stab <= stab + 2'h1;
      end
    end
  end
  property p_irq;
    irq_out_n_o == !($past(sh[6]) && $past(rx_irq_i));
  endproperty
  a_irq: assert property (p_irq) else $error("irq pin wrong");
  property p_init;
    stab == 2'h3 |-> receiver_init_en_o == (!sh[7] && !sh[4]);
  endproperty
  a_init: assert property (p_init) else $error("init en wrong");
  property p_prot;
    stab == 2'h3 |-> protect_setup_en_o == (!sh[7] && !sh[3]);
  endproperty
  a_prot: assert property (p_prot) else $error("prot en wrong");
  property p_tdm;
    stab == 2'h3 |-> audio_tdm_en_o == sh[2];
  endproperty
  a_tdm: assert property (p_tdm) else $error("tdm en wrong");
  property p_aux;
    stab == 2'h3 |-> aux_audio_en_o == sh[0];
  endproperty
  a_aux: assert property (p_aux) else $error("aux en wrong");
  property p_start;
    remote_load_start_o |-> !sh[5] ##1 !remote_load_start_o;
  endproperty
  a_start: assert property (p_start) else $error("load pulse wrong");
  property p_rd;
    reg_rd_i && reg_addr_i == ADDR_BRIDGE |=> reg_rdata_o == $past(sh);
  endproperty
  a_rd: assert property (p_rd) else $error("bridge read wrong");
  property p_unm;
    reg_rd_i && (reg_addr_i < ADDR_STATUS || reg_addr_i > ADDR_BRIDGE)
      |=> reg_rdata_o == 8'h00;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
endmodule
bind bsd_top bsd_chk u_chk (
  .sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o),
  .rx_irq_i(rx_irq_i),
  .irq_out_n_o(irq_out_n_o),
  .remote_load_start_o(remote_load_start_o),
  .receiver_init_en_o(receiver_init_en_o),
  .protect_setup_en_o(protect_setup_en_o),
  .audio_tdm_en_o(audio_tdm_en_o),
  .aux_audio_en_o(aux_audio_en_o),
  .strap_pin_a_i(strap_pin_a_i),
  .strap_pin_b_i(strap_pin_b_i)
);

// File: bsd_host.sv
`timescale 1ns/1ps
module bsd_host (
  // Clock
  input wire logic clk_i,
  // Device drive of the data line
  input wire logic sda_oe_i,
  input wire logic sda_dev_i,
  // Bus lines at the pins
  output logic scl_o,
  output logic sda_o
);
  logic drv;
  // Pull-up level unless a party pulls low
  assign sda_o = drv && !(sda_oe_i && !sda_dev_i);
  initial
  begin
    scl_o = 1'b1;
    drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Waits out any device pull-down before the edge
  task automatic start();
    drv <= 1'b1;
    tick(40);
    scl_o <= 1'b1;
    tick(8);
    drv <= 1'b0;
    tick(8);
    scl_o <= 1'b0;
    tick(4);
  endtask
  task automatic stop();
    drv <= 1'b0;
    tick(32);
    scl_o <= 1'b1;
    tick(8);
    drv <= 1'b1;
    tick(8);
  endtask
  // 40 ns high; low stretched past the output delay
  task automatic bit_io(input logic b, output logic s);
    drv <= b;
    tick(40);
    scl_o <= 1'b1;
    tick(4);
    s = sda_o;
    scl_o <= 1'b0;
    tick(4);
  endtask
  // MSB first, then the acknowledge slot
  task automatic byte_io(input logic [7:0] tx, input logic ak_in,
                         output logic [7:0] rx, output logic ak);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ak_in, ak);
  endtask
endmodule

// File: tb.sv
`timescale 1ns/1ps
module tb;
  import bsd_pkg::*;
  logic sys_clk_i, rst_n_i, reg_wr_i, reg_rd_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, v, b;
  logic ddc_scl_i, ddc_sda_i, ddc_sda_o, ddc_sda_oe_o;
  logic strap_pin_a_i, strap_pin_b_i, rx_irq_i, irq_out_n_o, k;
  logic remote_wr_i, remote_done_i, remote_load_start_o;
  logic [7:0] remote_addr_i, remote_data_i;
  logic receiver_init_en_o, protect_setup_en_o;
  logic audio_tdm_en_o, aux_audio_en_o;
  logic [2:0] ac;
  int error_cnt, n_checks, n_load;
  localparam logic [7:0] RST[6] = '{8'h00, 8'hA0, 8'h1E, 8'h00, 8'h00, 8'h00};
  localparam logic [23:0] WT[7] = '{24'h53FF03, 24'h52FF7F, 24'h54FFFF,
    24'h540202, 24'h5AFF00, 24'h50FF00, 24'h521010};
  localparam logic [7:0] BT[6] = '{8'h80, 8'h10, 8'h08, 8'h04, 8'h01, 8'h00};
  bsd_top DUT (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .ddc_scl_i(ddc_scl_i),
    .ddc_sda_i(ddc_sda_i),
    .ddc_sda_o(ddc_sda_o),
    .ddc_sda_oe_o(ddc_sda_oe_o),
    .strap_pin_a_i(strap_pin_a_i),
    .strap_pin_b_i(strap_pin_b_i),
    .rx_irq_i(rx_irq_i),
    .irq_out_n_o(irq_out_n_o),
    .remote_wr_i(remote_wr_i),
    .remote_addr_i(remote_addr_i),
    .remote_data_i(remote_data_i),
    .remote_done_i(remote_done_i),
    .remote_load_start_o(remote_load_start_o),
    .receiver_init_en_o(receiver_init_en_o),
    .protect_setup_en_o(protect_setup_en_o),
    .audio_tdm_en_o(audio_tdm_en_o),
    .aux_audio_en_o(aux_audio_en_o)
  );
  bsd_host u_host (.clk_i(sys_clk_i), .sda_oe_i(ddc_sda_oe_o),
    .sda_dev_i(ddc_sda_o), .scl_o(ddc_scl_i), .sda_o(ddc_sda_i));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [7:0] e);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= ad;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, e);
  endtask
  // Counts load-start pulses across both resets
  always @(posedge sys_clk_i)
    if (remote_load_start_o)
      n_load++;
  task automatic ddc_ptr(input logic [7:0] dv, input logic [7:0] p,
                         output logic [1:0] a);
    logic [7:0] x;
    u_host.start();
    u_host.byte_io(dv, 1'b1, x, a[1]);
    u_host.byte_io(p, 1'b1, x, a[0]);
  endtask
  task automatic ddc_wr(input logic [7:0] dv, input logic [7:0] p,
                        input logic [7:0] d, output logic [2:0] a);
    logic [7:0] x;
    ddc_ptr(dv, p, a[2:1]);
    u_host.byte_io(d, 1'b1, x, a[0]);
    u_host.stop();
  endtask
  task automatic ddc_rd(input logic [7:0] dv, input logic [7:0] p,
                        output logic [7:0] d);
    logic [1:0] a;
    logic x;
    ddc_ptr(dv, p, a);
    u_host.start();
    u_host.byte_io(dv | 8'h01, 1'b1, d, x);
    u_host.byte_io(8'hFF, 1'b1, d, x);
    u_host.stop();
  endtask
  initial
  begin
    repeat (100000) @(posedge sys_clk_i);
    error_cnt++;
    results();
  end
  initial
  begin
    {rst_n_i, reg_wr_i, reg_rd_i, rx_irq_i} = 4'h0;
    {reg_addr_i, reg_wdata_i, remote_addr_i, remote_data_i} = 32'h0;
    {strap_pin_a_i, strap_pin_b_i, remote_wr_i, remote_done_i} = 4'h0;
    error_cnt = 0;
    n_checks = 0;
    n_load = 0;
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    for (int i = 0; i < 6; i++)
      rchk(8'h50 + i, RST[i]);
    chk(8'(n_load), 8'h01);
    for (int i = 0; i < 7; i++)
    begin
      wr(WT[i][23:16], WT[i][15:8]);
      rchk(WT[i][23:16], WT[i][7:0]);
    end
    for (int i = 0; i < 6; i++)
    begin
      b = BT[i];
      wr(8'h54, b);
      repeat (3) @(posedge sys_clk_i);
      #1;
      v = {4'h0, ~b[7] & ~b[4], ~b[7] & ~b[3], b[2], b[0]};
      chk({4'h0, receiver_init_en_o, protect_setup_en_o, audio_tdm_en_o,
        aux_audio_en_o}, v);
    end
    @(posedge sys_clk_i);
    rx_irq_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk(irq_out_n_o, 1'b1);
    rchk(ADDR_STATUS, 8'h40);
    wr(ADDR_BRIDGE, 8'h40);
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk(irq_out_n_o, 1'b0);
    wr(ADDR_BRIDGE, 8'h00);
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk(irq_out_n_o, 1'b1);
    @(posedge sys_clk_i);
    rx_irq_i <= 1'b0;
    remote_wr_i <= 1'b1;
    remote_addr_i <= 8'h10;
    remote_data_i <= 8'h5A;
    @(posedge sys_clk_i);
    remote_wr_i <= 1'b0;
    remote_done_i <= 1'b1;
    @(posedge sys_clk_i);
    remote_done_i <= 1'b0;
    rchk(ADDR_STATUS, 8'h08);
    ddc_rd(8'hA0, 8'h10, v);
    chk(v, 8'h5A);
    ddc_wr(8'hA0, 8'h20, 8'h3C, ac);
    chk(ac, 3'b000);
    ddc_rd(8'hA0, 8'h20, v);
    chk(v, 8'h3C);
    wr(ADDR_DESC_ID, 8'hA1);
    ddc_wr(8'hA0, 8'h20, 8'hC3, ac);
    chk(ac, 3'b001);
    ddc_rd(8'hA0, 8'h20, v);
    chk(v, 8'h3C);
    wr(ADDR_DESC_ID, 8'h60);
    ddc_wr(8'hA0, 8'h20, 8'hC3, ac);
    chk(ac[2], 1'b1);
    ddc_rd(8'h60, 8'h20, v);
    chk(v, 8'h3C);
    // Second reset with both straps high
    strap_pin_a_i <= 1'b1;
    strap_pin_b_i <= 1'b1;
    rst_n_i <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    #1;
    chk({5'h00, receiver_init_en_o, protect_setup_en_o, aux_audio_en_o},
      8'h01);
    rchk(ADDR_BRIDGE, 8'hA1);
    chk(8'(n_load), 8'h01);
    results();
  end
endmodule
